// file: rtl/pgfw_pkg.sv
// Package for the power-good fault and watchdog window configuration slice
package pgfw_pkg;
    // Printed offsets are indexes; byte address is four times the index
    localparam logic [7:0] PGFW_IDX_FAULT = 8'h1B;
    localparam logic [7:0] PGFW_IDX_WCFG = 8'h1C;
    localparam logic [7:0] PGFW_IDX_SEL = 8'h1A;
    localparam logic [7:0] PGFW_IDX_LOCK = 8'h1D;
    localparam logic [7:0] PGFW_IDX_IRQ_STAT = 8'h20;
    localparam logic [7:0] PGFW_IDX_IRQ_MASK = 8'h21;
    localparam logic [7:0] PGFW_IDX_WSTAT = 8'h22;
    localparam logic [7:0] PGFW_RESET_FAULT = 8'h00;
    localparam logic [7:0] PGFW_RESET_SEL = 8'h00;
    localparam logic [6:0] PGFW_FLAG_MASK = 7'h7F;
    localparam int PGFW_LOCK_BIT = 7;
    localparam int PGFW_CLOSE_LSB = 6;
    localparam int PGFW_OPEN_LSB = 4;
    localparam int PGFW_LONG_LSB = 2;
    localparam int PGFW_THR_LSB = 0;
    localparam int PGFW_IRQ_FAULT_BIT = 0;
    localparam int PGFW_IRQ_RESTART_BIT = 1;
    localparam int PGFW_CLK_HZ = 25000000;
    // Window durations in ms, indexed by field code
    localparam int PGFW_CLOSE_MS [4] = '{10, 20, 50, 100};
    localparam int PGFW_OPEN_MS [4] = '{20, 100, 200, 600};
    localparam int PGFW_LONG_MS [4] = '{200, 600, 2000, 5000};
    localparam int PGFW_CYC_PER_MS = PGFW_CLK_HZ / 1000;
    localparam logic [1:0] PGFW_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] PGFW_HTRANS_SEQ = 2'h3;

    typedef struct packed {
        logic [1:0] close_sel;
        logic [1:0] open_sel;
        logic [1:0] long_sel;
        logic [1:0] thr_sel;
    } pgfw_wcfg_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] idx;
    } pgfw_addr_s;
endpackage

// file: rtl/pgfw_regs.sv
// Power-good fault flags and watchdog window configuration registers
module pgfw_regs
    import pgfw_pkg::*;
#(
    parameter int CNT_W = 3
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [6:0] src_fault,
    input wire logic [7:0] otp_wcfg,
    input wire logic wdog_reset_output,
    output logic power_good_out_b,
    output logic [7:0] wcfg_out,
    output logic [31:0] close_cycles,
    output logic [31:0] open_cycles,
    output logic [31:0] long_cycles,
    output logic system_restart,
    output logic irq
);
    // Counter must reach the largest threshold of four
    if (CNT_W < 3)
    begin : g_cnt_w_check
        $error("CNT_W must hold a count of four");
    end

    pgfw_addr_s aph;
    logic [6:0] fault;
    logic [6:0] sel;
    pgfw_wcfg_s wcfg;
    logic wdog_config_lock;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [CNT_W-1:0] pulse_cnt;
    logic pulse_d;
    logic otp_load;

    wire logic take = hsel && hready && hsize == 3'h2
        && (htrans == PGFW_HTRANS_NONSEQ || htrans == PGFW_HTRANS_SEQ);
    wire logic wr = aph.valid && aph.write;
    wire logic rd = aph.valid && !aph.write;
    wire logic wr_fault = wr && aph.idx == PGFW_IDX_FAULT;
    wire logic wr_wcfg = wr && aph.idx == PGFW_IDX_WCFG;
    wire logic wr_sel = wr && aph.idx == PGFW_IDX_SEL;
    wire logic wr_lock = wr && aph.idx == PGFW_IDX_LOCK;
    wire logic wr_mask = wr && aph.idx == PGFW_IDX_IRQ_MASK;
    wire logic rd_stat = rd && aph.idx == PGFW_IDX_IRQ_STAT;
    // Read data picked in the address phase so the flop holds it in data
    wire logic rd_take = take && !hwrite;
    wire logic [7:0] ridx = haddr[9:2];
    wire logic [6:0] active = src_fault & sel;
    // clear only bits whose source is valid; set wins
    wire logic [6:0] clr = wr_fault ? (hwdata[6:0] & ~src_fault) : 7'h00;
    // zero bits and bit 7 do nothing
    wire logic [6:0] next_fault = (fault & ~clr) | active;
    wire logic pulse_rise = wdog_reset_output && !pulse_d;
    wire logic [CNT_W-1:0] thr =
        wcfg.thr_sel == 2'h1 ? CNT_W'(1) :
        wcfg.thr_sel == 2'h2 ? CNT_W'(2) :
        wcfg.thr_sel == 2'h3 ? CNT_W'(4) : '0;
    wire logic restart_hit = pulse_rise && thr != '0
        && pulse_cnt + CNT_W'(1) >= thr;
    wire logic [1:0] ev = {restart_hit, |(active & ~fault)};
    wire logic [31:0] rdata =
        ridx == PGFW_IDX_FAULT ? {25'h0, fault} :
        ridx == PGFW_IDX_WCFG ? {24'h0, wcfg} :
        ridx == PGFW_IDX_SEL ? {25'h0, sel} :
        ridx == PGFW_IDX_LOCK ? {24'h0, wdog_config_lock, 7'h00} :
        ridx == PGFW_IDX_IRQ_STAT ? {30'h0, irq_stat} :
        ridx == PGFW_IDX_IRQ_MASK ? {30'h0, irq_mask} :
        ridx == PGFW_IDX_WSTAT ? {{(32-CNT_W){1'b0}}, pulse_cnt} :
        32'h0;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            aph <= '0;
        else if (hready)
            aph <= '{take, hwrite, haddr[9:2]};
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            fault <= PGFW_RESET_FAULT[6:0];
            sel <= PGFW_RESET_SEL[6:0];
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            wdog_config_lock <= 1'b0;
        end
        else
        begin
            fault <= next_fault & PGFW_FLAG_MASK;
            if (wr_sel)
                sel <= hwdata[6:0];
            if (wr_mask)
                irq_mask <= hwdata[1:0];
            // Lock only sets; reset alone clears it
            if (wr_lock && hwdata[PGFW_LOCK_BIT])
                wdog_config_lock <= 1'b1;
            // Clear only what the read returned; a later event survives
            irq_stat <= (irq_stat & ~(rd_stat ? hrdata[1:0] : 2'h0)) | ev;
        end
    end

    // otp defaults caught one edge after reset release
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            otp_load <= 1'b1;
        else
            otp_load <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            wcfg <= '0;
        else if (otp_load)
            wcfg <= otp_wcfg;
        else if (wr_wcfg && !wdog_config_lock)
            wcfg <= hwdata[7:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pulse_d <= 1'b0;
            pulse_cnt <= '0;
            system_restart <= 1'b0;
        end
        else
        begin
            pulse_d <= wdog_reset_output;
            system_restart <= restart_hit;
            if (restart_hit)
                pulse_cnt <= '0;
            else if (pulse_rise && thr != '0)
                pulse_cnt <= pulse_cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            hrdata <= 32'h0;
            power_good_out_b <= 1'b0;
            wcfg_out <= 8'h00;
            close_cycles <= 32'h0;
            open_cycles <= 32'h0;
            long_cycles <= 32'h0;
            irq <= 1'b0;
        end
        else
        begin
            if (rd_take)
                hrdata <= rdata;
            power_good_out_b <= ~|active;
            wcfg_out <= wcfg;
            close_cycles <= PGFW_CLOSE_MS[wcfg.close_sel] * PGFW_CYC_PER_MS;
            open_cycles <= PGFW_OPEN_MS[wcfg.open_sel] * PGFW_CYC_PER_MS;
            // long open window from bits 3:2
            long_cycles <= PGFW_LONG_MS[wcfg.long_sel] * PGFW_CYC_PER_MS;
            irq <= |(irq_stat & irq_mask);
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    a_flag_set_source: assert property (@(posedge sys_clk) disable iff (reset)
        (src_fault[6] && sel[6]) |=> fault[6])
        else $error("thermal flag not set");
    a_flag_analog_set: assert property (@(posedge sys_clk) disable iff (reset)
        (src_fault[5] && sel[5]) |=> fault[5])
        else $error("analog flag not set");
    a_masked_no_set: assert property (@(posedge sys_clk) disable iff (reset)
        (!fault[3] && !(src_fault[3] && sel[3])) |=> !fault[3])
        else $error("masked source set flag");
    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset)
        (fault[0] && !(wr_fault && hwdata[0])) |=> fault[0])
        else $error("flag dropped without clear");
    a_clear_valid: assert property (@(posedge sys_clk) disable iff (reset)
        (wr_fault && hwdata[4] && !src_fault[4]) |=> !fault[4])
        else $error("flag not cleared");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (reset)
        (aph.valid && !aph.write && aph.idx == PGFW_IDX_FAULT)
        |=> hrdata[7] == 1'b0)
        else $error("reserved bit not zero");
    a_lock_holds: assert property (@(posedge sys_clk) disable iff (reset)
        (wdog_config_lock && !otp_load) |=> $stable(wcfg))
        else $error("locked config changed");
    a_thr_zero_never: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.thr_sel == 2'h0) |=> !system_restart)
        else $error("restart with threshold zero");
    a_thr_one_restart: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.thr_sel == 2'h1 && pulse_rise) |=> system_restart)
        else $error("restart missed");
    a_close_time: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.close_sel == 2'h2) |=> close_cycles == 32'd1250000)
        else $error("close window wrong");
    a_open_time: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.open_sel == 2'h3) |=> open_cycles == 32'd15000000)
        else $error("open window wrong");
    a_long_time: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.long_sel == 2'h3) |=> long_cycles == 32'd125000000)
        else $error("long window wrong");
    a_otp_load: assert property (@(posedge sys_clk)
        (reset ##1 !reset) |=> wcfg == $past(otp_wcfg))
        else $error("otp default not loaded");

    // Fault flag, power-good and irq checks
    a_mon_b_set: assert property (@(posedge sys_clk) disable iff (reset)
        (src_fault[4] && sel[4]) |=> fault[4])
        else $error("monitor b flag not set");
    a_mon_a_set: assert property (@(posedge sys_clk) disable iff (reset)
        (src_fault[3] && sel[3]) |=> fault[3])
        else $error("monitor a flag not set");
    a_boost_set: assert property (@(posedge sys_clk) disable iff (reset)
        (src_fault[2] && sel[2]) |=> fault[2])
        else $error("boost flag not set");
    a_buck_b_set: assert property (@(posedge sys_clk) disable iff (reset)
        (src_fault[1] && sel[1]) |=> fault[1])
        else $error("buck b flag not set");
    a_buck_a_set: assert property (@(posedge sys_clk) disable iff (reset)
        (src_fault[0] && sel[0]) |=> fault[0])
        else $error("buck a flag not set");
    a_thermal_quiet: assert property (@(posedge sys_clk) disable iff (reset)
        (!fault[6] && !(src_fault[6] && sel[6])) |=> !fault[6])
        else $error("thermal flag set without cause");
    a_set_enabled: assert property (@(posedge sys_clk) disable iff (reset)
        1'b1 |=> (fault & ~$past(fault) & ~$past(active)) == 7'h00)
        else $error("flag set by masked source");
    a_clear_applies: assert property (@(posedge sys_clk) disable iff (reset)
        wr_fault |=> (fault & $past(clr)) == 7'h00)
        else $error("valid flag not cleared");
    a_clear_blocked: assert property (@(posedge sys_clk) disable iff (reset)
        (wr_fault && hwdata[6] && src_fault[6] && fault[6]) |=> fault[6])
        else $error("flag cleared while faulting");
    a_zero_write: assert property (@(posedge sys_clk) disable iff (reset)
        (wr_fault && hwdata[6:0] == 7'h00)
        |=> fault == ($past(fault) | $past(active)))
        else $error("zero write changed flags");
    a_reset_clear: assert property (@(posedge sys_clk)
        reset |=> fault == 7'h00)
        else $error("flags not zero after reset");
    a_fault_readback: assert property (@(posedge sys_clk) disable iff (reset)
        (rd_take && ridx == PGFW_IDX_FAULT)
        |=> hrdata == {25'h0, $past(fault)})
        else $error("fault read data wrong");
    a_pg_good: assert property (@(posedge sys_clk) disable iff (reset)
        (active == 7'h00) |=> power_good_out_b)
        else $error("power good low without cause");
    a_pg_bad: assert property (@(posedge sys_clk) disable iff (reset)
        (active != 7'h00) |=> !power_good_out_b)
        else $error("power good high with cause");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
        ((irq_stat & irq_mask) != 2'h0) |=> irq)
        else $error("irq not raised");

    // Window config, restart and lock checks
    a_close_min: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.close_sel == 2'h0) |=> close_cycles == 32'h0003D090)
        else $error("close window wrong");
    a_open_min: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.open_sel == 2'h0) |=> open_cycles == 32'h0007A120)
        else $error("open window wrong");
    a_long_min: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.long_sel == 2'h0) |=> long_cycles == 32'h004C4B40)
        else $error("long window wrong");
    a_thr_two: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.thr_sel == 2'h2 && pulse_rise && pulse_cnt == CNT_W'(1))
        |=> system_restart)
        else $error("restart missed at two");
    a_thr_four: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.thr_sel == 2'h3 && pulse_rise && pulse_cnt == CNT_W'(3))
        |=> system_restart)
        else $error("restart missed at four");
    a_thr_not_early: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.thr_sel == 2'h3 && pulse_rise && pulse_cnt == CNT_W'(2))
        |=> !system_restart)
        else $error("restart too early");
    a_cnt_restart: assert property (@(posedge sys_clk) disable iff (reset)
        system_restart |-> pulse_cnt == '0)
        else $error("pulse count not cleared");
    a_thr_zero_hold: assert property (@(posedge sys_clk) disable iff (reset)
        (wcfg.thr_sel == 2'h0) |=> $stable(pulse_cnt))
        else $error("pulses counted while disabled");
    a_otp_applied: assert property (@(posedge sys_clk) disable iff (reset)
        otp_load |=> wcfg == $past(otp_wcfg))
        else $error("otp default not applied");
    a_lock_sticky: assert property (@(posedge sys_clk) disable iff (reset)
        wdog_config_lock |=> wdog_config_lock)
        else $error("lock dropped without reset");
    a_cfg_write: assert property (@(posedge sys_clk) disable iff (reset)
        (wr_wcfg && !wdog_config_lock && !otp_load)
        |=> {24'h0, wcfg} == ($past(hwdata) & 32'h000000FF))
        else $error("unlocked config write lost");
    a_restart_event: assert property (@(posedge sys_clk) disable iff (reset)
        restart_hit |=> irq_stat[1])
        else $error("restart event not recorded");
endmodule // pgfw_regs

// file: verification/test_pgood_fault_and_wdog_config.sv
// Self-checking bench for the fault flag and window config registers
module test_pgood_fault_and_wdog_config
    import pgfw_pkg::*;
;
timeunit 1ns;
timeprecision 1ps;
localparam logic [31:0] A_FLT = {22'h0, PGFW_IDX_FAULT, 2'h0};
localparam logic [31:0] A_CFG = {22'h0, PGFW_IDX_WCFG, 2'h0};
localparam logic [31:0] A_SEL = {22'h0, PGFW_IDX_SEL, 2'h0};
localparam logic [31:0] A_LCK = {22'h0, PGFW_IDX_LOCK, 2'h0};
localparam logic [31:0] A_IST = {22'h0, PGFW_IDX_IRQ_STAT, 2'h0};
localparam logic [31:0] A_IMK = {22'h0, PGFW_IDX_IRQ_MASK, 2'h0};
logic sys_clk = 1'h0;
logic reset = 1'h1;
logic hsel = 1'h0;
logic hwrite = 1'h0;
logic wdog_reset_output = 1'h0;
logic [31:0] haddr = 32'h0;
logic [31:0] hwdata = 32'h0;
logic [1:0] htrans = 2'h0;
logic [2:0] hsize = 3'h2;
logic [6:0] src_fault = 7'h00;
// Arbitrary default, chosen so every field differs from zero
logic [7:0] otp_wcfg = 8'hB6;
logic [31:0] hrdata, close_cycles, open_cycles, long_cycles, rd;
logic hreadyout, hresp, power_good_out_b, system_restart, irq;
logic [7:0] wcfg_out;
int n_fail = 0, comparisons = 0, cycles = 0, n_restart = 0, base;
int thr [3] = '{1, 2, 3};
int npl [3] = '{1, 2, 4};
pgfw_regs #(.CNT_W(3)) pgfw_regs_inst (.sys_clk(sys_clk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_fault(src_fault),
    .otp_wcfg(otp_wcfg), .wdog_reset_output(wdog_reset_output),
    .power_good_out_b(power_good_out_b), .wcfg_out(wcfg_out),
    .close_cycles(close_cycles), .open_cycles(open_cycles),
    .long_cycles(long_cycles), .system_restart(system_restart), .irq(irq));
always #20 sys_clk = ~sys_clk;
task automatic close_out;
    if (n_fail == 0 && comparisons > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
// Hang guard: whole run needs a few hundred cycles
always @(posedge sys_clk)
begin
    cycles++;
    if (system_restart === 1'b1)
        n_restart++;
    if (cycles == 20000)
    begin
        n_fail++;
        close_out();
    end
end
task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
        n_fail++;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
endtask
// Address phase held until hready, then data phase until hready again
task automatic bus(logic wr, logic [31:0] addr, logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'h1;
    hwrite <= wr;
    haddr <= addr;
    htrans <= PGFW_HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'h0;
endtask
task automatic rdchk(string what, logic [31:0] addr, logic [7:0] exp);
    bus(1'h0, addr, 32'h0);
    chk(what, {24'h0, rd[7:0]}, {24'h0, exp});
    chk("resp", {31'h0, hresp}, 32'h0);
endtask
task automatic pulse;
    @(posedge sys_clk);
    wdog_reset_output <= 1'h1;
    repeat (2) @(posedge sys_clk);
    wdog_reset_output <= 1'h0;
    repeat (2) @(posedge sys_clk);
endtask
task automatic t_reset;
    rdchk("fault rst", A_FLT, 8'h00);
    rdchk("cfg otp", A_CFG, 8'hB6);
    rdchk("unmapped", 32'hF0, 8'h00);
endtask
task automatic t_flags;
    bus(1'h1, A_SEL, 32'h3F);
    bus(1'h1, A_IMK, 32'h03);
    for (int i = 0; i < 7; i++)
    begin
        src_fault <= 7'(1 << i);
        repeat (3) @(posedge sys_clk);
        chk("pg out", {31'h0, power_good_out_b}, {31'h0, i == 6});
        src_fault <= 7'h00;
        bus(1'h1, A_FLT, 32'h0);
        rdchk("flag", A_FLT, (i == 6) ? 8'h00 : 8'(1 << i));
        bus(1'h1, A_FLT, 32'(1 << i));
        rdchk("flag clr", A_FLT, 8'h00);
    end
    bus(1'h1, A_SEL, 32'h7F);
    src_fault <= 7'h40;
    repeat (3) @(posedge sys_clk);
    // Clear while source still faulting must not take
    bus(1'h1, A_FLT, 32'hC0);
    rdchk("flag held", A_FLT, 8'h40);
    chk("irq on", {31'h0, irq}, 32'h1);
    bus(1'h1, A_IMK, 32'h00);
    repeat (2) @(posedge sys_clk);
    chk("irq mask", {31'h0, irq}, 32'h0);
    src_fault <= 7'h00;
    bus(1'h1, A_FLT, 32'h40);
    rdchk("flag off", A_FLT, 8'h00);
    bus(1'h1, A_IMK, 32'h03);
    repeat (2) @(posedge sys_clk);
    chk("irq back", {31'h0, irq}, 32'h1);
    rdchk("irq stat", A_IST, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk("irq clr", {31'h0, irq}, 32'h0);
    rdchk("irq stat clr", A_IST, 8'h00);
endtask
task automatic t_window;
    for (int c = 0; c < 4; c++)
    begin
        bus(1'h1, A_CFG, 32'({c[1:0], c[1:0], c[1:0], 2'h0}));
        repeat (3) @(posedge sys_clk);
        chk("close", close_cycles, 32'(PGFW_CLOSE_MS[c] * PGFW_CYC_PER_MS));
        chk("open", open_cycles, 32'(PGFW_OPEN_MS[c] * PGFW_CYC_PER_MS));
        chk("long", long_cycles, 32'(PGFW_LONG_MS[c] * PGFW_CYC_PER_MS));
        chk("cfg out", {24'h0, wcfg_out}, 32'({c[1:0], c[1:0], c[1:0], 2'h0}));
    end
endtask
task automatic t_restart;
    for (int k = 0; k < 3; k++)
    begin
        bus(1'h1, A_CFG, 32'(thr[k]));
        base = n_restart;
        repeat (npl[k] - 1) pulse();
        repeat (6) @(posedge sys_clk);
        chk("early", 32'(n_restart - base), 32'h0);
        pulse();
        repeat (6) @(posedge sys_clk);
        chk("restart", 32'(n_restart - base), 32'h1);
    end
    bus(1'h1, A_CFG, 32'h0);
    base = n_restart;
    repeat (5) pulse();
    repeat (6) @(posedge sys_clk);
    chk("disabled", 32'(n_restart - base), 32'h0);
endtask
task automatic t_lock;
    bus(1'h1, A_CFG, 32'h55);
    bus(1'h1, A_LCK, 32'h80);
    bus(1'h1, A_CFG, 32'hAA);
    rdchk("locked", A_CFG, 8'h55);
    @(posedge sys_clk);
    reset <= 1'h1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rdchk("cfg otp 2", A_CFG, 8'hB6);
    bus(1'h1, A_CFG, 32'hAA);
    rdchk("unlocked", A_CFG, 8'hAA);
endtask
initial
begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'h0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_flags();
    t_window();
    t_restart();
    t_lock();
    close_out();
end
endmodule // test_pgood_fault_and_wdog_config
